// *** hw/alu_bit_branch_exec.sv ***
// Purpose: decode and execute add, and, bit set/clear and relative jumps
// Assumes: instruction word and file read data are stable for a whole cycle
// Notes: phase 3 is the write phase; instruction cycle is four clocks
module alu_bit_branch_exec (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [15:0] instr_in, // word being executed
  input wire logic [7:0] file_rdata_in, // data memory read value
  input wire logic [3:0] bank_pointer_in, // bank select register
  output exec_pkg::file_req_t file_req_out, // data memory request
  output logic [exec_pkg::PC_W-1:0] pc_out, // program counter
  output logic [7:0] acc_out, // accumulator
  output logic [4:0] flags_out, // n, ov, z, dc, c
  output logic cycle_end_out, // last phase of an instruction cycle
  output logic flush_out // second cycle of a taken jump, executes as nop
);
  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  exec_pkg::exec_state_s_t s_r; // registered state
  exec_pkg::exec_state_s_t s_nxt; // next state

  // bank-qualified file address
  function automatic logic [11:0] file_addr(input logic [15:0] ins, input logic [3:0] bank);
    // access bit low: access bank, bit 7 picks low ram or high sfr page
    if (!ins[8]) begin
      file_addr = ins[7] ? {4'hF, ins[7:0]} : {4'h0, ins[7:0]};
    end else begin
      file_addr = {bank, ins[7:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic is_addc, is_and, is_bclr, is_bset, is_cond, is_bra;
  logic cond_ok;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] alu_res;
  logic [7:0] bit_mask;
  logic [exec_pkg::PC_W-1:0] pc_inc, cond_tgt, bra_tgt;

  always_comb begin
    is_addc = instr_in[15:10] == exec_pkg::OP_ADD_WITH_CARRY_TO_FILE;
    is_and = instr_in[15:10] == exec_pkg::OP_AND_ACCUMULATOR_FILE;
    is_bclr = instr_in[15:12] == exec_pkg::OP_CLEAR_FILE_BIT;
    is_bset = instr_in[15:12] == exec_pkg::OP_SET_FILE_BIT;
    is_cond = instr_in[15:12] == exec_pkg::OP_COND_PREFIX;
    is_bra = instr_in[15:11] == exec_pkg::OP_UNCONDITIONAL_JUMP;
    // condition code picks one flag and a polarity
    unique case (instr_in[11:8])
      exec_pkg::CC_JUMP_IF_CARRY: cond_ok = s_r.flags[exec_pkg::FLAG_C];
      exec_pkg::CC_JUMP_IF_NEGATIVE: cond_ok = s_r.flags[exec_pkg::FLAG_N];
      exec_pkg::CC_JUMP_IF_NOT_NEGATIVE: cond_ok = !s_r.flags[exec_pkg::FLAG_N];
      exec_pkg::CC_JUMP_IF_NO_CARRY: cond_ok = !s_r.flags[exec_pkg::FLAG_C];
      exec_pkg::CC_JUMP_IF_NO_OVERFLOW: cond_ok = !s_r.flags[exec_pkg::FLAG_OV];
      exec_pkg::CC_JUMP_IF_NONZERO: cond_ok = !s_r.flags[exec_pkg::FLAG_Z];
      default: cond_ok = 1'b0; // other codes lie outside this block
    endcase
    // carry-in add, digit carry from the low nibble
    sum9 = {1'b0, s_r.acc} + {1'b0, file_rdata_in} + {8'h00, s_r.flags[exec_pkg::FLAG_C]};
    low5 = {1'b0, s_r.acc[3:0]} + {1'b0, file_rdata_in[3:0]} + {4'h0, s_r.flags[exec_pkg::FLAG_C]};
    alu_res = is_addc ? sum9[7:0] : (s_r.acc & file_rdata_in);
    bit_mask = 8'h01 << instr_in[11:9];
    // pc points at this word; pc_inc steps 2 past it
    pc_inc = s_r.pc + 21'h000002;
    cond_tgt = pc_inc + {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
    bra_tgt = pc_inc + {{9{instr_in[10]}}, instr_in[10:0], 1'b0};
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.phase = s_r.phase + 2'h1;
    s_nxt.wr_en = 1'b0;
    if (s_r.phase == exec_pkg::PHASE_LAST) begin
      unique case (s_r.st)
        exec_pkg::ST_FLUSH: begin
          // second cycle of a taken jump: nop
          s_nxt.st = exec_pkg::ST_EXEC;
        end
        exec_pkg::ST_EXEC: begin
          s_nxt.pc = pc_inc;
          if (is_addc || is_and) begin
            if (instr_in[9]) begin
              s_nxt.wr_en = 1'b1;
              s_nxt.wr_addr = file_addr(instr_in, bank_pointer_in);
              s_nxt.wr_data = alu_res;
            end else begin
              s_nxt.acc = alu_res;
            end
            s_nxt.flags[exec_pkg::FLAG_N] = alu_res[7];
            s_nxt.flags[exec_pkg::FLAG_Z] = alu_res == 8'h00;
            if (is_addc) begin
              s_nxt.flags[exec_pkg::FLAG_C] = sum9[8];
              s_nxt.flags[exec_pkg::FLAG_DC] = low5[4];
              s_nxt.flags[exec_pkg::FLAG_OV] = (s_r.acc[7] == file_rdata_in[7]) && (alu_res[7] != s_r.acc[7]);
            end
          end else if (is_bclr || is_bset) begin
            // flags untouched
            s_nxt.wr_en = 1'b1;
            s_nxt.wr_addr = file_addr(instr_in, bank_pointer_in);
            s_nxt.wr_data = is_bset ? (file_rdata_in | bit_mask) : (file_rdata_in & ~bit_mask);
          end else if (is_cond && cond_ok) begin
            s_nxt.pc = cond_tgt;
            s_nxt.st = exec_pkg::ST_FLUSH;
          end else if (is_bra) begin
            s_nxt.pc = bra_tgt;
            s_nxt.st = exec_pkg::ST_FLUSH;
          end
        end
      endcase
    end
  end

  // one register for all state
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_r <= '{st: exec_pkg::ST_EXEC, phase: 2'h0, pc: exec_pkg::PC_RESET, acc: exec_pkg::ACC_RESET,
               flags: exec_pkg::FLAGS_RESET, wr_addr: 12'h000, wr_en: 1'b0, wr_data: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    // read address presented except in the clock of a registered write pulse, which shows wr_addr
    file_req_out.addr = s_r.wr_en ? s_r.wr_addr : file_addr(instr_in, bank_pointer_in);
    file_req_out.rd = (s_r.st == exec_pkg::ST_EXEC) && !s_r.wr_en;
    file_req_out.wr = s_r.wr_en;
    file_req_out.wdata = s_r.wr_data;
    pc_out = s_r.pc;
    acc_out = s_r.acc;
    flags_out = s_r.flags;
    cycle_end_out = s_r.phase == exec_pkg::PHASE_LAST;
    flush_out = s_r.st == exec_pkg::ST_FLUSH;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_bclr_writes_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_bclr |=> file_req_out.wr && !file_req_out.wdata[$past(instr_in[11:9])])
    else $error("bit clear did not write zero");
  a_bset_writes_one: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_bset |=> file_req_out.wr && file_req_out.wdata[$past(instr_in[11:9])])
    else $error("bit set did not write one");
  a_bit_flags_kept: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && (is_bclr || is_bset) |=> $stable(flags_out))
    else $error("bit op changed flags");
  a_taken_two_cycles: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_cond && cond_ok |=> flush_out [*4] ##1 !flush_out)
    else $error("taken branch not two cycles");
  a_untaken_one_cycle: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_cond && !cond_ok |=> !flush_out && pc_out == $past(pc_out) + 21'h000002)
    else $error("untaken branch misbehaved");
  a_branch_target: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_cond && cond_ok |=> pc_out == $past(cond_tgt))
    else $error("branch target wrong");
  a_bra_always: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_bra |=> flush_out && pc_out == $past(bra_tgt))
    else $error("unconditional jump not taken");
  a_and_to_acc: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_and && !instr_in[9] |=> acc_out == ($past(acc_out) & $past(file_rdata_in))
      && flags_out[exec_pkg::FLAG_C] == $past(flags_out[exec_pkg::FLAG_C]))
    else $error("and result or carry wrong");
  a_addc_carry: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && is_addc |=> flags_out[exec_pkg::FLAG_C] == $past(sum9[8]))
    else $error("add carry wrong");
  a_dest_file: assert property (@(posedge mclk_in) disable iff (srst_in)
    cycle_end_out && !flush_out && (is_addc || is_and) && instr_in[9] |=> file_req_out.wr && $stable(acc_out))
    else $error("file destination not honoured");
  a_access_bank: assert property (@(posedge mclk_in) disable iff (srst_in)
    !s_r.wr_en && !instr_in[8] |-> file_req_out.addr[11:8] == (instr_in[7] ? 4'hF : 4'h0))
    else $error("access bank address wrong");
endmodule

// *** common/exec_pkg.sv ***
// Purpose: shared constants and types for the alu, bit and branch executor
// Assumes: 16-bit instruction words, 8-bit data, byte-addressed program counter
// Notes: four phases per instruction cycle, counted by the executor
package exec_pkg;
  // ------------------------------------------------------------
  // opcode fields
  // ------------------------------------------------------------
  localparam logic [5:0] OP_ADD_WITH_CARRY_TO_FILE = 6'h08; // 0010 00
  localparam logic [5:0] OP_AND_ACCUMULATOR_FILE = 6'h05; // 0001 01
  localparam logic [3:0] OP_CLEAR_FILE_BIT = 4'h9;
  localparam logic [3:0] OP_SET_FILE_BIT = 4'h8;
  localparam logic [3:0] OP_COND_PREFIX = 4'hE;
  localparam logic [4:0] OP_UNCONDITIONAL_JUMP = 5'h1A; // 1101 0
  localparam logic [3:0] CC_JUMP_IF_NONZERO = 4'h1;
  localparam logic [3:0] CC_JUMP_IF_CARRY = 4'h2;
  localparam logic [3:0] CC_JUMP_IF_NO_CARRY = 4'h3;
  localparam logic [3:0] CC_JUMP_IF_NO_OVERFLOW = 4'h5;
  localparam logic [3:0] CC_JUMP_IF_NEGATIVE = 4'h6;
  localparam logic [3:0] CC_JUMP_IF_NOT_NEGATIVE = 4'h7;
  // ------------------------------------------------------------
  // widths, flag positions and reset values
  // ------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef enum {ST_EXEC, ST_FLUSH} exec_state_t;

  // file memory request toward the data memory
  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } file_req_t;

  // whole executor state
  typedef struct packed {
    exec_state_t st;
    logic [1:0] phase;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [11:0] wr_addr;
    logic wr_en;
    logic [7:0] wr_data;
  } exec_state_s_t;
endpackage

// *** testbench/alu_bit_branch_exec_tb.sv ***
// Purpose: self-checking bench for the alu, bit and branch executor
// Assumes: one instruction per four clocks, results land one clock after phase 3
// Notes: random instruction mix from a fixed seed, checked against an inline model
module alu_bit_branch_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // design hookup
  // ------------------------------------------------------------
  logic mclk_in, srst_in; // clock, sync reset
  logic [15:0] instr_in; // word under execution
  logic [7:0] file_rdata_in; // file read value
  logic [3:0] bank_pointer_in; // bank select
  exec_pkg::file_req_t file_req_out;
  logic [exec_pkg::PC_W-1:0] pc_out;
  logic [7:0] acc_out;
  logic [4:0] flags_out;
  logic cycle_end_out, flush_out;
  int failures, samples_checked;
  logic [20:0] m_pc; // model program counter
  logic [7:0] m_acc; // model accumulator
  logic [4:0] m_fl; // model flags
  bit first_instr; // phase count unknown before first execute
  logic [3:0] ccs [6]; // condition codes in the block's set
  alu_bit_branch_exec alu_bit_branch_exec_i (.mclk_in(mclk_in), .srst_in(srst_in), .instr_in(instr_in),
    .file_rdata_in(file_rdata_in), .bank_pointer_in(bank_pointer_in), .file_req_out(file_req_out),
    .pc_out(pc_out), .acc_out(acc_out), .flags_out(flags_out), .cycle_end_out(cycle_end_out),
    .flush_out(flush_out));
  // free-running 50 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // ------------------------------------------------------------
  // compare and verdict
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // waits bounded for the write phase; returns edges waited
  task automatic wait_end(output int n);
    n = 0;
    while (cycle_end_out !== 1'b1 && n < 16) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
  endtask
  // ------------------------------------------------------------
  // one instruction: drive, model, compare
  // ------------------------------------------------------------
  task automatic run_instr(input logic [15:0] ins, input logic [7:0] rd, input logic [3:0] bp);
    int n;
    logic [8:0] sum;
    logic [4:0] dc;
    logic [7:0] res;
    logic [11:0] fa;
    logic take, wr_exp, alu, c;
    take = 0;
    wr_exp = 0;
    alu = 0;
    res = 8'h00;
    c = m_fl[exec_pkg::FLAG_C];
    instr_in = ins;
    file_rdata_in = rd;
    bank_pointer_in = bp;
    // access bank splits at 0x80, otherwise bank pointer on top
    fa = ins[8] ? {bp, ins[7:0]} : {{4{ins[7]}}, ins[7:0]};
    wait_end(n);
    if (!first_instr) check("phase count", n, 3);
    first_instr = 0;
    if (ins[15:14] != 2'b11) check("read addr", file_req_out.addr, fa);
    check("read strobe", file_req_out.rd, 1'b1);
    m_pc = m_pc + 21'h2;
    if (ins[15:10] == exec_pkg::OP_ADD_WITH_CARRY_TO_FILE) begin
      sum = m_acc + rd + c;
      dc = m_acc[3:0] + rd[3:0] + c;
      res = sum[7:0];
      alu = 1;
      m_fl = {res[7], (m_acc[7] == rd[7]) && (res[7] != m_acc[7]), res == 8'h00, dc[4], sum[8]};
    end else if (ins[15:10] == exec_pkg::OP_AND_ACCUMULATOR_FILE) begin
      res = m_acc & rd;
      alu = 1;
      m_fl[exec_pkg::FLAG_N] = res[7];
      m_fl[exec_pkg::FLAG_Z] = res == 8'h00;
    end else if (ins[15:12] == exec_pkg::OP_CLEAR_FILE_BIT) begin
      res = rd & ~(8'h01 << ins[11:9]);
      wr_exp = 1;
    end else if (ins[15:12] == exec_pkg::OP_SET_FILE_BIT) begin
      res = rd | (8'h01 << ins[11:9]);
      wr_exp = 1;
    end else if (ins[15:12] == exec_pkg::OP_COND_PREFIX) begin
      case (ins[11:8])
        exec_pkg::CC_JUMP_IF_CARRY: take = c;
        exec_pkg::CC_JUMP_IF_NEGATIVE: take = m_fl[exec_pkg::FLAG_N];
        exec_pkg::CC_JUMP_IF_NOT_NEGATIVE: take = !m_fl[exec_pkg::FLAG_N];
        exec_pkg::CC_JUMP_IF_NO_CARRY: take = !c;
        exec_pkg::CC_JUMP_IF_NO_OVERFLOW: take = !m_fl[exec_pkg::FLAG_OV];
        exec_pkg::CC_JUMP_IF_NONZERO: take = !m_fl[exec_pkg::FLAG_Z];
        default: take = 0;
      endcase
      if (take) m_pc = m_pc + {{12{ins[7]}}, ins[7:0], 1'b0};
    end else if (ins[15:11] == exec_pkg::OP_UNCONDITIONAL_JUMP) begin
      take = 1;
      m_pc = m_pc + {{9{ins[10]}}, ins[10:0], 1'b0};
    end
    // destination bit picks accumulator or file
    if (alu && ins[9]) wr_exp = 1;
    else if (alu) m_acc = res;
    @(posedge mclk_in);
    #1;
    check("pc", pc_out, m_pc);
    check("acc", acc_out, m_acc);
    check("flags", flags_out, m_fl);
    check("write pulse", file_req_out.wr, wr_exp);
    if (wr_exp) check("write addr", file_req_out.addr, fa);
    if (wr_exp) check("write data", file_req_out.wdata, res);
    check("flush", flush_out, take);
    if (take) begin
      // junk word during the dead cycle must change nothing
      instr_in = {exec_pkg::OP_SET_FILE_BIT, 12'h010};
      wait_end(n);
      check("flush read", file_req_out.rd, 1'b0);
      @(posedge mclk_in);
      #1;
      check("flush pc", pc_out, m_pc);
      check("flush write", file_req_out.wr, 1'b0);
      check("flush end", flush_out, 1'b0);
    end
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] ins;
    r = $urandom(72);
    ccs = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    srst_in = 1'b1;
    instr_in = 16'h0000;
    file_rdata_in = 8'h00;
    bank_pointer_in = 4'h0;
    {m_pc, m_acc, m_fl} = '0;
    first_instr = 1;
    repeat (16) @(posedge mclk_in);
    #1 srst_in = 1'b0;
    for (int i = 0; i < 500; i++) begin
      r = $urandom;
      case ($urandom_range(6))
        0: ins = {exec_pkg::OP_ADD_WITH_CARRY_TO_FILE, r[9:0]};
        1: ins = {exec_pkg::OP_AND_ACCUMULATOR_FILE, r[9:0]};
        2: ins = {exec_pkg::OP_CLEAR_FILE_BIT, r[11:0]};
        3: ins = {exec_pkg::OP_SET_FILE_BIT, r[11:0]};
        4: ins = {exec_pkg::OP_COND_PREFIX, ccs[r[31:29] % 6], r[7:0]};
        5: ins = {exec_pkg::OP_UNCONDITIONAL_JUMP, r[10:0]};
        default: ins = {4'hF, r[11:0]};
      endcase
      run_instr(ins, r[19:12], r[23:20]);
      // mid-run reset: state must return to its start values
      if (i == 400) begin
        srst_in = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
        check("reset pc", pc_out, exec_pkg::PC_RESET);
        check("reset acc", acc_out, exec_pkg::ACC_RESET);
        check("reset flags", flags_out, exec_pkg::FLAGS_RESET);
        check("reset flush", flush_out, 1'b0);
        check("reset write", file_req_out.wr, 1'b0);
        srst_in = 1'b0;
        {m_pc, m_acc, m_fl} = '0;
      end
    end
    close_out();
  end
  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
